// *** cte_exec.sv ***
// Command table entry executor: applies parameter updates, then plays.
// Assumes the sequencer holds entry fields steady from run_entry_request on
// until entry_busy falls; wave memory answers in 1 cycle.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Waveform selector 0..15999 plays the waveform bound to that slot.
// - Play length in samples, minimum 16; absent length uses declared span.
// - Samples advance at base rate divided by two to the exponent 0..13.
// - Zero fill emits zeros; hold last repeats last sample and marker.
// - Oscillator choice 0..7 selects the modulation oscillator.
// - Phase range is -180 up to excluding 180; outside values clamp.
// - Phase increment flag adds; otherwise phase is replaced.
// - Four gain terms each limited to -1.0 .. 1.0 per channel path.
// - Gain increment flag adds; otherwise gain is loaded absolute.
// - Absent elements leave settings; entry without waveform, zero fill or hold last only updates.
// - Any phase in table zeroes absolute phase when execution starts.
module cte_exec
  import cte_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // Execution start
  input  wire logic                         exec_start,
  input  wire logic                         table_has_phase,
  // Entry request
  input  wire logic                         run_entry_request,
  input  wire logic [ENTRY_W-1:0]           entry_index,
  output logic                              entry_busy,
  output logic                              entry_error,
  // Waveform element
  input  wire logic                         wave_present,
  input  wire logic [WAVE_SEL_W-1:0]        wave_select,
  input  wire logic                         length_present,
  input  wire logic [LEN_W-1:0]             play_length,
  input  wire logic [EXP_W-1:0]             rate_divide_exponent,
  input  wire logic                         zero_fill_flag,
  input  wire logic                         hold_last_flag,
  // Oscillator and phase elements
  input  wire logic                         osc_present,
  input  wire logic [OSC_W-1:0]             osc_choice,
  input  wire logic                         phase_present,
  input  wire logic signed [PHASE_W-1:0]    phase_value,
  input  wire logic                         phase_over,
  input  wire logic                         phase_under,
  input  wire logic                         phase_increment,
  // Gain elements a..d
  input  wire logic [3:0]                   gain_present,
  input  wire logic [3:0][GAIN_W-1:0]       gain_value,
  input  wire logic [3:0]                   gain_increment,
  // Wave memory
  output logic [WAVE_SEL_W-1:0]             wave_slot_binding,
  output logic [LEN_W-1:0]                  wave_addr,
  input  wire logic [LEN_W-1:0]             declared_wave_span,
  input  wire logic [MARK_W+SAMPLE_W-1:0]   wave_word,
  // Sample stream
  output logic                              sample_valid,
  input  wire logic                         sample_ready,
  output logic [MARK_W+SAMPLE_W-1:0]        sample_word,
  // Datapath settings
  output logic [OSC_W-1:0]                  osc_sel,
  output logic [PHASE_W-1:0]                phase_now,
  output logic [3:0][GAIN_W-1:0]            gain_now
);
  typedef struct packed {
    cte_state_type               st;
    cte_src_type                 src;
    logic [LEN_W-1:0]            left;
    logic [LEN_W-1:0]            addr;
    logic [EXP_W-1:0]            exp;
    logic [13:0]                 div;
    logic                        err;
    logic [OSC_W-1:0]            osc;
    logic [PHASE_W-1:0]          phase;
    logic [3:0][GAIN_W-1:0]      gain;
    logic [MARK_W+SAMPLE_W-1:0]  last;
    logic                        word_ok;
  } cte_exec_state_type;

  cte_exec_state_type s_q;
  cte_exec_state_type s_d;
  logic                         fifo_ready;
  logic                         tick;
  logic [MARK_W+SAMPLE_W-1:0]   push_word;
  logic signed [PHASE_W:0]      ph_sum;
  logic signed [PHASE_W:0]      ph_clamp;
  logic [3:0][GAIN_W-1:0]       gain_next;
  logic [LEN_W-1:0]             len_pick;

  // Per-term gain update with saturation
  for (genvar g = 0; g < 4; g++) begin : g_gain
    logic signed [GAIN_W:0] gsum;
    always_comb begin
      gsum = gain_increment[g]
           ? $signed({s_q.gain[g][GAIN_W-1], s_q.gain[g]})
             + $signed({gain_value[g][GAIN_W-1], gain_value[g]})
           : $signed({gain_value[g][GAIN_W-1], gain_value[g]});
      if (!gain_present[g]) begin
        gain_next[g] = s_q.gain[g];
      end else if (gsum > GAIN_POS_MAX) begin
        gain_next[g] = GAIN_POS_MAX[GAIN_W-1:0];
      end else if (gsum < GAIN_NEG_MIN) begin
        gain_next[g] = GAIN_NEG_MIN[GAIN_W-1:0];
      end else begin
        gain_next[g] = gsum[GAIN_W-1:0];
      end
    end
  end

  always_comb begin
    // Out-of-range entry values arrive as flags and clamp to the ends
    if (phase_over) begin
      ph_clamp = PHASE_POS_MAX;
    end else if (phase_under) begin
      ph_clamp = PHASE_NEG_MIN;
    end else begin
      ph_clamp = {phase_value[PHASE_W-1], phase_value};
    end
    // Absolute phase wraps naturally on the half-open circle
    ph_sum = phase_increment
           ? {1'b0, s_q.phase} + {1'b0, ph_clamp[PHASE_W-1:0]}
           : ph_clamp;
    len_pick = length_present ? play_length : declared_wave_span;
    if (len_pick < MIN_LEN) begin
      len_pick = MIN_LEN;
    end
  end

  assign tick = s_q.div == '0;
  always_comb begin
    unique case (s_q.src)
      CTE_SRC_ZERO: push_word = ZERO_WORD;
      CTE_SRC_HOLD: push_word = s_q.last;
      default:      push_word = wave_word;
    endcase
  end

  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      CTE_IDLE: begin
        if (exec_start && table_has_phase) begin
          s_d.phase = PHASE_RESET;
        end
        if (run_entry_request) begin
          s_d.st = CTE_APPLY;
        end
      end
      CTE_APPLY: begin
        // Settings land here, before any sample of this entry enters the FIFO
        if (osc_present) begin
          s_d.osc = osc_choice;
        end
        if (phase_present) begin
          s_d.phase = ph_sum[PHASE_W-1:0];
        end
        s_d.gain = gain_next;
        s_d.exp  = (rate_divide_exponent > EXP_MAX) ? EXP_MAX : rate_divide_exponent;
        s_d.div  = '0;
        s_d.addr = '0;
        s_d.left = len_pick;
        s_d.word_ok = 1'b0;
        s_d.err  = wave_present && !zero_fill_flag && !hold_last_flag
                   && (wave_select > WAVE_SEL_MAX);
        if (zero_fill_flag) begin
          s_d.src = CTE_SRC_ZERO;
          s_d.st  = CTE_PLAY;
        end else if (hold_last_flag) begin
          s_d.src = CTE_SRC_HOLD;
          s_d.st  = CTE_PLAY;
        end else if (wave_present && !s_d.err) begin
          s_d.src = CTE_SRC_WAVE;
          s_d.st  = CTE_PLAY;
        end else begin
          s_d.st  = CTE_IDLE;
        end
      end
      CTE_PLAY: begin
        // Wave memory has one cycle latency after address change
        s_d.word_ok = 1'b1;
        if (s_q.word_ok && fifo_ready) begin
          // Each slot costs a fetch cycle, so the divided rate stays exact
          s_d.word_ok = 1'b0;
          if (tick) begin
            s_d.addr = s_q.addr + 1'b1;
            s_d.left = s_q.left - 1'b1;
            if (s_q.src != CTE_SRC_HOLD) begin
              s_d.last = push_word;
            end
            if (s_q.left == 24'h000001) begin
              s_d.st = CTE_IDLE;
            end
          end
          s_d.div = (s_q.div == (14'h0001 << s_q.exp) - 14'h0001)
                  ? '0 : s_q.div + 14'h0001;
        end
      end
      default: s_d.st = CTE_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q       <= '0;
      s_q.st    <= CTE_IDLE;
      s_q.src   <= CTE_SRC_WAVE;
      s_q.exp   <= EXP_DEFAULT;
      s_q.osc   <= OSC_RESET;
      s_q.phase <= PHASE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  cte_fifo #(
    .WIDTH (MARK_W+SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (s_q.st == CTE_PLAY && s_q.word_ok && tick),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  (sample_word)
  );

  assign entry_busy        = s_q.st != CTE_IDLE;
  assign entry_error       = s_q.err;
  assign wave_slot_binding = wave_select;
  assign wave_addr         = s_q.addr;
  assign osc_sel           = s_q.osc;
  assign phase_now         = s_q.phase;
  assign gain_now          = s_q.gain;

  logic unused_ok;
  assign unused_ok = ^entry_index;

  sequence seq_apply;
    s_q.st == CTE_APPLY;
  endsequence

  a_apply_then_play: assert property (@(posedge clk) disable iff (!resetn)
    seq_apply ##1 (s_q.st == CTE_PLAY) |-> s_q.left >= MIN_LEN)
    else $error("play length below minimum");
  a_osc_load: assert property (@(posedge clk) disable iff (!resetn)
    seq_apply and osc_present |=> s_q.osc == $past(osc_choice))
    else $error("oscillator not loaded");
  a_osc_keep: assert property (@(posedge clk) disable iff (!resetn)
    s_q.st != CTE_APPLY |=> $stable(s_q.osc))
    else $error("oscillator changed outside apply");
  a_phase_start: assert property (@(posedge clk) disable iff (!resetn)
    s_q.st == CTE_IDLE && exec_start && table_has_phase |=> s_q.phase == PHASE_RESET)
    else $error("phase not cleared at start");
  a_phase_abs: assert property (@(posedge clk) disable iff (!resetn)
    seq_apply and phase_present && !phase_increment && !phase_over && !phase_under
    |=> s_q.phase == $past(phase_value))
    else $error("absolute phase not loaded");
  a_gain_range: assert property (@(posedge clk) disable iff (!resetn)
    $signed(s_q.gain[0]) <= $signed(GAIN_POS_MAX[GAIN_W-1:0])
    && $signed(s_q.gain[0]) >= $signed(GAIN_NEG_MIN[GAIN_W-1:0]))
    else $error("gain out of range");
  a_gain_abs: assert property (@(posedge clk) disable iff (!resetn)
    seq_apply and gain_present[1] && !gain_increment[1]
    |=> s_q.gain[1] == $past(gain_value[1]))
    else $error("absolute gain not loaded");
  a_zero_words: assert property (@(posedge clk) disable iff (!resetn)
    s_q.st == CTE_PLAY && s_q.src == CTE_SRC_ZERO |-> push_word == ZERO_WORD)
    else $error("zero fill emits data");
  a_no_play_idle: assert property (@(posedge clk) disable iff (!resetn)
    seq_apply and !wave_present && !zero_fill_flag && !hold_last_flag
    |=> s_q.st == CTE_IDLE)
    else $error("entry without waveform played");
  a_exp_range: assert property (@(posedge clk) disable iff (!resetn)
    s_q.exp <= EXP_MAX)
    else $error("rate exponent above limit");
  a_params_first: assert property (@(posedge clk) disable iff (!resetn)
    s_q.st == CTE_PLAY |=> $stable(s_q.gain) && $stable(s_q.phase))
    else $error("parameter changed during play");

  // One push per slot where the divider ticks; a slot always follows a fetch cycle
  sequence seq_push;
    s_q.st == CTE_PLAY && s_q.word_ok && tick && fifo_ready;
  endsequence

  a_push_after_apply: assert property (@(posedge clk) disable iff (!resetn)
    seq_push |-> $past(s_q.st) != CTE_APPLY)
    else $error("sample pushed right after apply");
  a_rate_gap: assert property (@(posedge clk) disable iff (!resetn)
    seq_push |=> !(s_q.word_ok && tick))
    else $error("samples pushed back to back");
  a_hold_keeps: assert property (@(posedge clk) disable iff (!resetn)
    seq_push and (s_q.src == CTE_SRC_HOLD) |=> $stable(s_q.last))
    else $error("hold sample changed");
  a_bad_slot: assert property (@(posedge clk) disable iff (!resetn)
    seq_apply and wave_present && !zero_fill_flag && !hold_last_flag
    && wave_select > WAVE_SEL_MAX |=> s_q.err && s_q.st == CTE_IDLE)
    else $error("bad slot not refused");
endmodule
`default_nettype wire

// *** cte_pkg.sv ***
// Constants and types for the command table entry executor.
// Assumes a single 250 MHz clock and plain-port control.
package cte_pkg;
  // Field widths
  localparam int WAVE_SEL_W    = 14;
  localparam int LEN_W         = 24;
  localparam int EXP_W         = 4;
  localparam int OSC_W         = 3;
  localparam int PHASE_W       = 16;
  localparam int GAIN_W        = 18;
  localparam int SAMPLE_W      = 16;
  localparam int MARK_W        = 4;
  localparam int ENTRY_W       = 12;
  localparam int FIFO_DEPTH    = 16;
  // Limits
  localparam logic [WAVE_SEL_W-1:0] WAVE_SEL_MAX = 14'h3E7F;
  localparam logic [LEN_W-1:0]      MIN_LEN      = 24'h000010;
  localparam logic [EXP_W-1:0]      EXP_MAX      = 4'hD;
  localparam logic [EXP_W-1:0]      EXP_DEFAULT  = 4'h0;
  localparam logic [OSC_W-1:0]      OSC_RESET    = 3'h0;
  // Phase: signed fraction of a half turn, -180 maps to 8000, 180 excluded
  localparam logic signed [PHASE_W:0] PHASE_POS_MAX = 17'sh07FFF;
  localparam logic signed [PHASE_W:0] PHASE_NEG_MIN = -17'sh08000;
  localparam logic [PHASE_W-1:0]      PHASE_RESET   = 16'h0000;
  // Gain: signed Q1.16, +1.0 = 10000
  localparam logic signed [GAIN_W:0] GAIN_POS_MAX  = 19'sh10000;
  localparam logic signed [GAIN_W:0] GAIN_NEG_MIN  = -19'sh10000;
  localparam logic [GAIN_W-1:0]      GAIN_RESET    = 18'h00000;
  localparam logic [MARK_W+SAMPLE_W-1:0] ZERO_WORD = 20'h00000;

  typedef enum logic [1:0] {
    CTE_IDLE,
    CTE_APPLY,
    CTE_PLAY
  } cte_state_type;

  typedef enum logic [1:0] {
    CTE_SRC_WAVE,
    CTE_SRC_ZERO,
    CTE_SRC_HOLD
  } cte_src_type;
endpackage

// *** cte_fifo.sv ***
// Sample FIFO between the entry executor and the sample stream.
// Assumes same-clock producer and consumer.
`timescale 1ns/1ns
`default_nettype none
module cte_fifo
  import cte_pkg::*;
#(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } cte_fifo_state_type;

  cte_fifo_state_type s_q;
  cte_fifo_state_type s_d;
  logic [WIDTH-1:0]   mem_q [DEPTH];
  logic               push;
  logic               pop;

  assign in_ready  = s_q.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_q.cnt != '0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[s_q.rd];

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage carries no reset; only valid words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[s_q.wr] <= in_data;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!resetn)
    s_q.cnt == (AW+1)'(DEPTH) |-> !push)
    else $error("fifo pushed while full");
endmodule
`default_nettype wire

// *** cte_mem_model.sv ***
// Wave memory model standing behind the entry executor.
// Assumes the executor reads one word every two cycles with one cycle of latency.
`timescale 1ns/1ns
`default_nettype none
module cte_mem_model
  import cte_pkg::*;
(
  // Clock
  input  wire logic                       clk,
  // Lookup
  input  wire logic [WAVE_SEL_W-1:0]      wave_slot_binding,
  input  wire logic [LEN_W-1:0]           wave_addr,
  // Answer
  output logic [LEN_W-1:0]                declared_wave_span,
  output var logic [MARK_W+SAMPLE_W-1:0]  wave_word
);
  // Word depends on slot bits 3..0 and address, so a wrong low slot bit or skipped address shows
  always_ff @(posedge clk) begin
    wave_word <= {wave_slot_binding[3:0], wave_addr[15:0] ^ 16'hA5C3};
  end
  // Span differs with slot bits 2..0 so a fixed length cannot pass by chance
  assign declared_wave_span = 24'h000010 + {21'h000000, wave_slot_binding[2:0]};
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the command table entry executor.
// Assumes cte_exec, cte_fifo and the wave memory model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import cte_pkg::*;
  logic                        clk, resetn, exec_start, table_has_phase, run_entry_request;
  logic                        wave_present, length_present, zero_fill_flag, hold_last_flag;
  logic                        osc_present, phase_present, phase_over, phase_under;
  logic                        phase_increment, sample_ready, entry_busy, entry_error;
  logic                        sample_valid;
  logic [ENTRY_W-1:0]          entry_index;
  logic [WAVE_SEL_W-1:0]       wave_select, wave_slot_binding;
  logic [LEN_W-1:0]            play_length, wave_addr, declared_wave_span;
  logic [EXP_W-1:0]            rate_divide_exponent;
  logic [OSC_W-1:0]            osc_choice, osc_sel, osc_first;
  logic signed [PHASE_W-1:0]   phase_value;
  logic [PHASE_W-1:0]          phase_now;
  logic [3:0]                  gain_present, gain_increment;
  logic [3:0][GAIN_W-1:0]      gain_value, gain_now;
  logic [MARK_W+SAMPLE_W-1:0]  wave_word, sample_word;
  logic [MARK_W+SAMPLE_W-1:0]  got_q[$];
  int                          miscompares, comparisons, busy_cycles;

  cte_exec u_cte_exec (.clk, .resetn, .exec_start, .table_has_phase, .run_entry_request,
    .entry_index, .entry_busy, .entry_error, .wave_present, .wave_select, .length_present,
    .play_length, .rate_divide_exponent, .zero_fill_flag, .hold_last_flag, .osc_present,
    .osc_choice, .phase_present, .phase_value, .phase_over, .phase_under, .phase_increment,
    .gain_present, .gain_value, .gain_increment, .wave_slot_binding, .wave_addr,
    .declared_wave_span, .wave_word, .sample_valid, .sample_ready, .sample_word, .osc_sel,
    .phase_now, .gain_now);
  cte_mem_model u_cte_mem_model (.clk, .wave_slot_binding, .wave_addr, .declared_wave_span,
    .wave_word);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Stream sink; osc_sel captured as the first sample leaves
  always @(posedge clk) begin
    if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
      if (got_q.size() == 0) osc_first = osc_sel;
      got_q.push_back(sample_word);
    end
  end

  function automatic logic [19:0] ew(input int s, input int a);
    return {4'(s), 16'(a) ^ 16'hA5C3};
  endfunction

  task automatic end_of_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic clr;
    {wave_present, length_present, zero_fill_flag, hold_last_flag} <= 4'h0;
    {osc_present, phase_present, phase_over, phase_under, phase_increment} <= 5'h00;
    wave_select <= '0;
    play_length <= '0;
    rate_divide_exponent <= '0;
    osc_choice <= '0;
    phase_value <= '0;
    {gain_present, gain_increment} <= 8'h00;
    gain_value <= '0;
  endtask

  // Fields were set one edge earlier and stay until the entry is done
  task automatic run;
    int n;
    got_q.delete();
    @(posedge clk);
    run_entry_request <= 1'b1;
    entry_index <= entry_index + 12'h001;
    @(posedge clk);
    run_entry_request <= 1'b0;
    busy_cycles = 0;
    #1;
    while (entry_busy !== 1'b0) begin
      @(posedge clk);
      #1;
      busy_cycles++;
      if (busy_cycles > 4000) begin
        chk_cnt(busy_cycles, 0, "busy hang");
        end_of_test();
      end
    end
    n = 0;
    while (sample_valid !== 1'b0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_cnt(n < 200, 1, "drain");
    if (n >= 200) end_of_test();
    @(posedge clk);
    clr();
  endtask

  task automatic t_reset;
    chk_val(osc_sel, OSC_RESET, "osc reset");
    chk_val(phase_now, PHASE_RESET, "phase reset");
    for (int i = 0; i < 4; i++) chk_val(gain_now[i], GAIN_RESET, "gain reset");
    chk_val({entry_busy, sample_valid}, 24'h0, "idle flags");
  endtask

  task automatic t_params;
    logic [GAIN_W-1:0] exp_g[4] = '{18'h08000, 18'h3C000, 18'h10000, 18'h00001};
    @(posedge clk);
    {osc_present, phase_present, osc_choice, phase_value} <= {2'b11, 3'h7, 16'h4000};
    gain_present <= 4'hF;
    gain_value <= {18'h00001, 18'h10000, 18'h3C000, 18'h08000};
    run();
    chk_val(osc_sel, 24'h7, "osc load");
    chk_val(phase_now, 24'h4000, "phase load");
    for (int i = 0; i < 4; i++) chk_val(gain_now[i], exp_g[i], "gain load");
    chk_cnt(got_q.size(), 0, "no wave plays");
  endtask

  task automatic t_incr;
    logic [GAIN_W-1:0] exp_g[4] = '{18'h10000, 18'h08000, 18'h10000, 18'h0C001};
    @(posedge clk);
    {phase_present, phase_increment, phase_value} <= {2'b11, 16'h6000};
    {gain_present, gain_increment} <= 8'hFF;
    gain_value <= {4{18'h0C000}};
    run();
    chk_val(phase_now, 24'hA000, "phase add");
    for (int i = 0; i < 4; i++) chk_val(gain_now[i], exp_g[i], "gain add");
    chk_val(osc_sel, 24'h7, "osc kept");
  endtask

  task automatic t_clamp;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      {phase_present, phase_over, phase_under} <= {1'b1, i == 0, i == 1};
      run();
      chk_val(phase_now, i == 0 ? 24'h7FFF : 24'h8000, "phase clamp");
    end
  endtask

  task automatic t_exec;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      {exec_start, table_has_phase} <= {1'b1, i == 1};
      @(posedge clk);
      exec_start <= 1'b0;
      @(posedge clk);
      #1;
      chk_val(phase_now, i == 1 ? 24'h0 : 24'h8000, "start phase");
    end
  endtask

  task automatic t_wave;
    @(posedge clk);
    {wave_present, wave_select, osc_present, osc_choice} <= {1'b1, 14'h0005, 1'b1, 3'h3};
    sample_ready <= 1'b0;
    fork
      begin
        repeat (60) @(posedge clk);
        #1;
        chk_val({sample_valid, 23'(got_q.size())}, 24'h800000, "fifo stalls");
        @(posedge clk);
        sample_ready <= 1'b1;
      end
    join_none
    run();
    chk_cnt(got_q.size(), 21, "declared span");
    for (int i = 0; i < got_q.size(); i++) chk_val(got_q[i], ew(5, i), "wave word");
    chk_val(osc_first, 24'h3, "osc before play");
  endtask

  task automatic t_hold_zero;
    @(posedge clk);
    {hold_last_flag, length_present, play_length} <= {2'b11, 24'h000010};
    run();
    chk_cnt(got_q.size(), 16, "hold count");
    foreach (got_q[i]) chk_val(got_q[i], ew(5, 20), "hold word");
    @(posedge clk);
    {zero_fill_flag, length_present, play_length} <= {2'b11, 24'h000004};
    run();
    chk_cnt(got_q.size(), 16, "min length");
    // Two cycles per base sample, 16 samples, one apply cycle first
    chk_cnt(busy_cycles, 33, "base rate");
    foreach (got_q[i]) chk_val(got_q[i], ZERO_WORD, "zero word");
    @(posedge clk);
    {zero_fill_flag, length_present, play_length} <= {2'b11, 24'h000010};
    rate_divide_exponent <= 4'h2;
    run();
    chk_cnt(busy_cycles, 123, "divided rate");
  endtask

  task automatic t_err;
    @(posedge clk);
    {wave_present, wave_select} <= {1'b1, 14'h3E80};
    run();
    chk_val({entry_error, 23'(got_q.size())}, 24'h800000, "bad slot");
    @(posedge clk);
    {wave_present, wave_select, length_present, play_length} <= {1'b1, WAVE_SEL_MAX, 1'b1, 24'h000010};
    run();
    chk_val(entry_error, 24'h0, "top slot ok");
    chk_cnt(got_q.size(), 16, "given length");
    foreach (got_q[i]) chk_val(got_q[i], ew(15999, i), "top slot word");
  endtask

  initial begin
    {resetn, exec_start, table_has_phase, run_entry_request} = 4'h0;
    entry_index = '0;
    sample_ready = 1'b1;
    miscompares = 0;
    comparisons = 0;
    clr();
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_params();
    t_incr();
    t_clamp();
    t_exec();
    t_wave();
    t_hold_zero();
    t_err();
    end_of_test();
  end
endmodule
`default_nettype wire
